// ==== hw/fcc_params.svh ====
// Constants for the CAN fault confinement block.
// Assumes inclusion by fcc_core only.
// Notes on behaviour
// - While transmitting, a monitored bit differing from the driven bit is a bit error.
// - Dominant over driven recessive is no bit error in passive flag, arbitration, ack.
// - Six equal consecutive bits in a stuffed field give a stuff error.
// - Wrong level on a fixed bit is a form error; receiver last EOF excepted.
// - Nonzero CRC remainder over a received frame gives a CRC error.
// - Transmitter seeing no dominant ack slot flags an acknowledgment error.
// - After enable or wake-up, wait for 11 recessive bits before going active.
// - Warning behaves as active; both counters below 96 returns to active.
// - Either counter above 127 makes passive; the causing error still gets active flag.
// - A passive node signals errors with recessive flags only.
// - Passive returns to active once both counters are below 128.
// - Transmit counter above 255 means bus off with drivers disabled.
// - Bus off ends after 128 groups of 11 recessive bits; counters cleared.
// - Both 8-bit counters sit in one 16-bit readable register.
// - Receive counter bit 7 set means passive and no further increment.
// - Receiver adds 8 for bit error in active flag or dominant after flag.
// - Add 8 at 14th dominant after active flag, 8th after passive, each 8 more.
// - Other errors add 1 to receive counter or 8 to transmit counter.
// - Transmitter adds 8 for a bit error while sending an active flag.
// - Each good reception or transmission decrements its counter, floor zero.
// - Arbitration stuff bit read back dominant does not raise the transmit counter.
// - Passive ack error with no dominant during passive flag does not raise it.
// - Error flags go out at once; data frames wait three intermission bits.
`ifndef FCC_PARAMS_SVH
`define FCC_PARAMS_SVH
`define FCC_OFF_ECNT   12'h000
`define FCC_OFF_CTRL   12'h004
`define FCC_OFF_STAT   12'h008
`define FCC_CTRL_EN    0
`define FCC_SYNC_BITS  4'd11
`define FCC_BOFF_GRPS  8'd128
`define FCC_STUFF_RUN  3'd5
`define FCC_WARN_LIM   9'd96
`define FCC_PASS_LIM   9'd127
`define FCC_BOFF_LIM   9'd255
`define FCC_INC_BIG    9'd8
`define FCC_INC_ONE    9'd1
`define FCC_DOM_ACT    4'd14
`define FCC_DOM_PAS    4'd8
`define FCC_DOM_STEP   4'd8
`define FCC_IFS_BITS   2'd3
`define FCC_CRC_POLY   15'h4599
`define FCC_DOM        1'b0
`define FCC_REC        1'b1
`endif

// ==== hw/fcc_pkg.sv ====
// Types shared by the fault confinement block and its bench.
// Assumes the frame engine supplies a per-bit context.
package fcc_pkg;
   typedef enum logic [4:0] {
      FCC_SYNC    = 5'b00001,
      FCC_ACTIVE  = 5'b00010,
      FCC_WARN    = 5'b00100,
      FCC_PASSIVE = 5'b01000,
      FCC_BUSOFF  = 5'b10000
   } fcc_state_t;
   typedef struct packed {
      logic tx_active;
      logic in_stuffed;
      logic in_arb;
      logic stuff_bit;
      logic ack_slot;
      logic fixed_bit;
      logic fixed_level;
      logic eof_last;
      logic sof;
      logic crc_data;
      logic crc_check;
      logic err_flag;
      logic flag_tail;
      logic ovl_tail;
      logic rx_ok;
      logic tx_ok;
      logic frame_end;
   } fcc_ctx_t;
   typedef struct packed {
      logic bit_err;
      logic stuff_err;
      logic form_err;
      logic crc_err;
      logic ack_err;
   } fcc_err_t;
endpackage

// ==== hw/fcc_core.sv ====
// Error detection and fault confinement of a CAN controller.
// Assumes a frame engine giving bit_tick_i at each sample point and a bit context.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "fcc_params.svh"
module fcc_core #(
   parameter int AW = 12
) (
   input  wire logic            mclk_i,
   input  wire logic            rst_i,
   input  wire logic            psel_i,
   input  wire logic            penable_i,
   input  wire logic            pwrite_i,
   input  wire logic [AW-1:0]   paddr_i,
   input  wire logic [31:0]     pwdata_i,
   input  wire logic [3:0]      pstrb_i,
   output logic      [31:0]     prdata_o,
   output logic                 pready_o,
   output logic                 pslverr_o,
   input  wire logic            bit_tick_i,
   input  wire logic            rx_bit_i,
   input  wire logic            tx_bit_i,
   input  wire fcc_pkg::fcc_ctx_t ctx_i,
   input  wire logic            wake_i,
   output fcc_pkg::fcc_err_t    err_o,
   output fcc_pkg::fcc_state_t  state_o,
   output logic                 drv_en_o,
   output logic                 flag_dom_o,
   output logic                 data_tx_ok_o,
   output logic [15:0]          ecnt_o
);
   import fcc_pkg::*;

   fcc_state_t state_q, state_d;
   fcc_err_t   err_d, err_q;
   logic [8:0] tec_q, tec_d;
   logic [7:0] rec_q, rec_d;
   logic       en_q, en_dly_q;
   logic [3:0] rcv_run_q;
   logic [7:0] grp_q;
   logic [2:0] run_q;
   logic       last_q;
   logic [14:0] crc_q;
   logic [3:0] dom_q;
   logic       dom_first_q;
   logic       flag_act_q;
   logic       ack_pend_q;
   logic [1:0] ifs_q;
   logic       restart;
   logic       tec_inc8, rec_inc8, rec_inc1, rec_dec, tec_dec;
   logic       any_err, crc_fb, dom_hit, part;
   logic       tx_acc, rd_acc;

   assign part    = (state_q != FCC_SYNC) && (state_q != FCC_BUSOFF);
   assign restart = (en_q && !en_dly_q) || wake_i;

   // Error detection per sampled bit
   always_comb begin
      err_d = '0;
      if (bit_tick_i && part) begin
         err_d.bit_err = ctx_i.tx_active && (rx_bit_i != tx_bit_i) &&
            !(tx_bit_i == `FCC_REC && rx_bit_i == `FCC_DOM &&
              ((ctx_i.err_flag && !flag_act_q) || ctx_i.in_arb ||
               ctx_i.ack_slot));
         err_d.stuff_err = ctx_i.in_stuffed && (run_q == `FCC_STUFF_RUN) &&
            (rx_bit_i == last_q);
         err_d.form_err = ctx_i.fixed_bit && (rx_bit_i != ctx_i.fixed_level) &&
            !(ctx_i.eof_last && !ctx_i.tx_active);
         err_d.crc_err = ctx_i.crc_check && !ctx_i.tx_active && (crc_q != '0);
         err_d.ack_err = ctx_i.tx_active && ctx_i.ack_slot &&
            (rx_bit_i == `FCC_REC);
      end
   end
   assign any_err = |err_d;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         err_q <= '0;
      end else begin
         err_q <= err_d;
      end
   end

   // Run length of equal levels for stuff check
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         run_q  <= '0;
         last_q <= `FCC_REC;
      end else if (bit_tick_i) begin
         last_q <= rx_bit_i;
         if (!ctx_i.in_stuffed || rx_bit_i != last_q) begin
            run_q <= 3'd1;
         end else if (run_q != `FCC_STUFF_RUN) begin
            run_q <= run_q + 3'd1;
         end
      end
   end

   assign crc_fb = rx_bit_i ^ crc_q[14];
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         crc_q <= '0;
      end else if (bit_tick_i && ctx_i.sof) begin
         crc_q <= '0;
      end else if (bit_tick_i && ctx_i.crc_data && !ctx_i.stuff_bit) begin
         crc_q <= {crc_q[13:0], 1'b0} ^ (crc_fb ? `FCC_CRC_POLY : 15'h0000);
      end
   end

   // flag kind chosen from state before update
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         flag_act_q <= 1'b1;
      end else if (any_err) begin
         flag_act_q <= (state_q == FCC_ACTIVE) || (state_q == FCC_WARN);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         dom_q       <= '0;
         dom_first_q <= 1'b0;
      end else if (bit_tick_i) begin
         if (!(ctx_i.flag_tail || ctx_i.ovl_tail)) begin
            dom_q       <= '0;
            dom_first_q <= 1'b1;
         end else begin
            dom_first_q <= 1'b0;
            if (rx_bit_i == `FCC_REC) begin
               dom_q <= '0;
            end else if (dom_hit) begin
               dom_q <= (flag_act_q || ctx_i.ovl_tail) ?
                        (`FCC_DOM_ACT - `FCC_DOM_STEP) : '0;
            end else begin
               dom_q <= dom_q + 4'd1;
            end
         end
      end
   end
   assign dom_hit = bit_tick_i && (ctx_i.flag_tail || ctx_i.ovl_tail) &&
      (rx_bit_i == `FCC_DOM) &&
      (((flag_act_q || ctx_i.ovl_tail) && dom_q == `FCC_DOM_ACT - 4'd1) ||
       (!flag_act_q && !ctx_i.ovl_tail && dom_q == `FCC_DOM_PAS - 4'd1));

   // passive ack error waits for a dominant bit in the flag
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ack_pend_q <= 1'b0;
      end else if (err_d.ack_err && state_q == FCC_PASSIVE) begin
         ack_pend_q <= 1'b1;
      end else if (bit_tick_i && !ctx_i.err_flag) begin
         ack_pend_q <= 1'b0;
      end else if (bit_tick_i && rx_bit_i == `FCC_DOM) begin
         ack_pend_q <= 1'b0;
      end
   end

   // Counter events
   always_comb begin
      tx_acc  = ctx_i.tx_active;
      rd_acc  = bit_tick_i && ctx_i.err_flag && flag_act_q &&
                (rx_bit_i != tx_bit_i);
      // transmitter bit error in active flag
      tec_inc8 = tx_acc && rd_acc;
      // receiver bit error in active flag
      rec_inc8 = !tx_acc && rd_acc;
      if (!tx_acc && bit_tick_i && ctx_i.flag_tail && dom_first_q &&
          rx_bit_i == `FCC_DOM) begin
         rec_inc8 = 1'b1;
      end
      if (dom_hit) begin
         tec_inc8 = tec_inc8 | tx_acc;
         rec_inc8 = rec_inc8 | !tx_acc;
      end
      // dominant seen in passive flag, count it now
      if (ack_pend_q && bit_tick_i && ctx_i.err_flag && rx_bit_i == `FCC_DOM) begin
         tec_inc8 = 1'b1;
      end
      rec_inc1 = !tx_acc && (err_d.stuff_err || err_d.form_err ||
                 err_d.crc_err || err_d.bit_err);
      if (tx_acc && (err_d.stuff_err || err_d.form_err || err_d.bit_err ||
          (err_d.ack_err && state_q != FCC_PASSIVE))) begin
         if (!(err_d.stuff_err && ctx_i.in_arb && ctx_i.stuff_bit &&
               tx_bit_i == `FCC_REC && rx_bit_i == `FCC_DOM)) begin
            tec_inc8 = 1'b1;
         end
      end
      rec_dec = bit_tick_i && ctx_i.rx_ok;
      tec_dec = bit_tick_i && ctx_i.tx_ok;
   end

   // Next counter values
   always_comb begin
      tec_d = tec_q;
      rec_d = rec_q;
      if (tec_inc8) begin
         tec_d = tec_q + `FCC_INC_BIG;
      end else if (tec_dec && tec_q != '0) begin
         tec_d = tec_q - `FCC_INC_ONE;
      end
      // receive counter stops rising once bit 7 is set
      if (!rec_q[7] && (rec_inc8 || rec_inc1)) begin
         rec_d = rec_q + 8'(rec_inc8 ? `FCC_INC_BIG : `FCC_INC_ONE);
      end else if (rec_dec && rec_q != '0) begin
         rec_d = rec_q - 8'd1;
      end
   end

   // Counter registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tec_q <= '0;
         rec_q <= '0;
      end else if (state_q == FCC_BUSOFF) begin
         // counters zero on leaving bus off
         if (grp_q == `FCC_BOFF_GRPS) begin
            tec_q <= '0;
            rec_q <= '0;
         end
      end else if (part) begin
         tec_q <= tec_d;
         rec_q <= rec_d;
      end
   end

   // Recessive run counting for sync and recovery
   always_ff @(posedge mclk_i) begin
      if (rst_i || restart) begin
         rcv_run_q <= '0;
         grp_q     <= '0;
      end else if (state_q == FCC_SYNC || state_q == FCC_BUSOFF) begin
         if (bit_tick_i) begin
            if (rx_bit_i == `FCC_DOM) begin
               rcv_run_q <= '0;
            end else if (rcv_run_q == `FCC_SYNC_BITS - 4'd1) begin
               rcv_run_q <= '0;
               grp_q     <= grp_q + 8'd1;
            end else begin
               rcv_run_q <= rcv_run_q + 4'd1;
            end
         end
      end else begin
         rcv_run_q <= '0;
         grp_q     <= '0;
      end
   end

   // Node state
   always_comb begin
      state_d = state_q;
      case (state_q)
         FCC_SYNC: begin
            if (grp_q != '0) begin
               state_d = FCC_ACTIVE;
            end
         end
         FCC_ACTIVE, FCC_WARN, FCC_PASSIVE: begin
            if (tec_d > `FCC_BOFF_LIM) begin
               state_d = FCC_BUSOFF;
            end else if (tec_d > `FCC_PASS_LIM || {1'b0, rec_d} > `FCC_PASS_LIM) begin
               state_d = FCC_PASSIVE;
            end else if (tec_d >= `FCC_WARN_LIM || {1'b0, rec_d} >= `FCC_WARN_LIM) begin
               state_d = FCC_WARN;
            end else begin
               state_d = FCC_ACTIVE;
            end
         end
         FCC_BUSOFF: begin
            if (grp_q == `FCC_BOFF_GRPS) begin
               state_d = FCC_ACTIVE;
            end
         end
         default: state_d = FCC_SYNC;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_q <= FCC_SYNC;
      end else if (restart || !en_q) begin
         state_q <= FCC_SYNC;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ifs_q <= '0;
      end else if (bit_tick_i) begin
         if (ctx_i.frame_end || any_err) begin
            ifs_q <= '0;
         end else if (rx_bit_i == `FCC_REC && ifs_q != `FCC_IFS_BITS) begin
            ifs_q <= ifs_q + 2'd1;
         end
      end
   end

   // Registered block outputs
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_o      <= FCC_SYNC;
         drv_en_o     <= 1'b0;
         flag_dom_o   <= 1'b1;
         data_tx_ok_o <= 1'b0;
         ecnt_o       <= '0;
         err_o        <= '0;
      end else begin
         state_o      <= state_q;
         drv_en_o     <= part;
         flag_dom_o   <= flag_act_q;
         data_tx_ok_o <= part && (ifs_q == `FCC_IFS_BITS);
         ecnt_o       <= {tec_q[7:0], rec_q};
         err_o        <= err_q;
      end
   end

   // Control register, enable bit steers synchronisation
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         en_q     <= 1'b0;
         en_dly_q <= 1'b0;
      end else begin
         en_dly_q <= en_q;
         if (psel_i && penable_i && pready_o && pwrite_i &&
             paddr_i == `FCC_OFF_CTRL && pstrb_i[0]) begin
            en_q <= pwdata_i[`FCC_CTRL_EN];
         end
      end
   end

   // APB slave, one wait state so every answer comes from a flop
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
      end else if (psel_i && penable_i && !pready_o) begin
         pready_o  <= 1'b1;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
         case (paddr_i)
            `FCC_OFF_ECNT: begin
               prdata_o[15:0] <= {tec_q[7:0], rec_q};
               pslverr_o      <= pwrite_i;
            end
            `FCC_OFF_CTRL: prdata_o[`FCC_CTRL_EN] <= en_q;
            `FCC_OFF_STAT: begin
               prdata_o[4:0] <= state_q;
               prdata_o[8]   <= tec_q[8];
               pslverr_o     <= pwrite_i;
            end
            default: pslverr_o <= 1'b1;
         endcase
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end
endmodule

// ==== bench/fcc_bus_node.sv ====
// Model of the other CAN nodes sharing the bus with the core.
// Assumes the bench decides when they ack or force dominant bits.
`timescale 1ns/1ps
module fcc_bus_node (
   input  wire logic tx_bit_i,
   input  wire logic ack_slot_i,
   input  wire logic ack_en_i,
   input  wire logic dom_i,
   output logic      rx_bit_o
);
   // Wired-AND bus; no node acks unless told, so ack faults stay reachable
   assign rx_bit_o = tx_bit_i & ~dom_i & ~(ack_en_i & ack_slot_i);
endmodule

// ==== bench/fcc_core_asserts.sv ====
// Concurrent checks on the fault confinement core ports.
// Assumes bind into fcc_core; bit inputs settle at bit_tick_i.
`timescale 1ns/1ps
module fcc_core_asserts
   import fcc_pkg::*;
(
   input wire logic                mclk_i,
   input wire logic                rst_i,
   input wire logic                bit_tick_i,
   input wire logic                rx_bit_i,
   input wire logic                tx_bit_i,
   input wire logic                wake_i,
   input wire fcc_pkg::fcc_ctx_t   ctx_i,
   input wire fcc_pkg::fcc_err_t   err_o,
   input wire fcc_pkg::fcc_state_t state_o,
   input wire logic                drv_en_o,
   input wire logic [15:0]         ecnt_o
);
   logic [3:0] rrun_q;
   // Saturates so a long idle never wraps back below eleven
   always_ff @(posedge mclk_i) begin
      if (rst_i || wake_i || (bit_tick_i && !rx_bit_i)) rrun_q <= 4'h0;
      else if (bit_tick_i && rrun_q != 4'hF) rrun_q <= rrun_q + 4'h1;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_sync_exit;
      state_o == FCC_ACTIVE && $past(state_o) == FCC_SYNC |-> $past(rrun_q, 2) >= 4'hB;
   endproperty
   a_sync_exit: assert property (p_sync_exit)
      else $error("sync left too early");
   property p_ack;
      bit_tick_i && drv_en_o && ctx_i.tx_active && ctx_i.ack_slot && rx_bit_i
         |-> ##[2:3] err_o.ack_err;
   endproperty
   a_ack: assert property (p_ack)
      else $error("missing ack error");
   property p_bit;
      bit_tick_i && drv_en_o && ctx_i.tx_active && !ctx_i.in_arb && !ctx_i.ack_slot
         && !ctx_i.err_flag && tx_bit_i != rx_bit_i |-> ##[2:3] err_o.bit_err;
   endproperty
   a_bit: assert property (p_bit)
      else $error("missing bit error");
   property p_no_bit;
      bit_tick_i && ctx_i.tx_active && (ctx_i.in_arb || ctx_i.ack_slot) && tx_bit_i && !rx_bit_i
         |-> ##2 !err_o.bit_err ##1 !err_o.bit_err;
   endproperty
   a_no_bit: assert property (p_no_bit)
      else $error("bit error on excused bit");
   property p_ack_inc;
      bit_tick_i && ctx_i.tx_active && ctx_i.ack_slot && rx_bit_i
         && state_o inside {FCC_ACTIVE, FCC_WARN} ##1 1'b1
         |=> ecnt_o[15:8] == $past(ecnt_o[15:8]) + 8'h08;
   endproperty
   a_ack_inc: assert property (p_ack_inc)
      else $error("transmit count not raised by 8");
   property p_dec;
      bit_tick_i && ctx_i.tx_ok && drv_en_o ##1 ecnt_o[15:8] != 8'h00
         |=> ecnt_o[15:8] == $past(ecnt_o[15:8]) - 8'h01;
   endproperty
   a_dec: assert property (p_dec)
      else $error("transmit count not lowered by 1");
   property p_active;
      state_o == FCC_ACTIVE |-> ecnt_o[15:8] < 8'h60 && ecnt_o[7:0] < 8'h60;
   endproperty
   a_active: assert property (p_active)
      else $error("active with a count at warning level");
   property p_warn;
      state_o == FCC_WARN |-> (ecnt_o[15:8] >= 8'h60 || ecnt_o[7:0] >= 8'h60)
         && ecnt_o[15:8] < 8'h80 && ecnt_o[7:0] < 8'h80;
   endproperty
   a_warn: assert property (p_warn)
      else $error("warning with counts out of range");
   property p_passive;
      state_o == FCC_PASSIVE |-> ecnt_o[15:8] > 8'h7F || ecnt_o[7:0] > 8'h7F;
   endproperty
   a_passive: assert property (p_passive)
      else $error("passive with both counts low");
   property p_rec_hold;
      ecnt_o[7] && $past(ecnt_o[7]) |-> ecnt_o[7:0] <= $past(ecnt_o[7:0]);
   endproperty
   a_rec_hold: assert property (p_rec_hold)
      else $error("receive count rose past bit 7");
   property p_boff_drv;
      state_o == FCC_BUSOFF && $past(state_o) == FCC_BUSOFF |-> !drv_en_o;
   endproperty
   a_boff_drv: assert property (p_boff_drv)
      else $error("drivers on while bus off");
   property p_boff_clr;
      $past(state_o) == FCC_BUSOFF && state_o != FCC_BUSOFF
         |-> state_o == FCC_ACTIVE && ecnt_o == 16'h0000;
   endproperty
   a_boff_clr: assert property (p_boff_clr)
      else $error("bus off exit without cleared counts");
endmodule
bind fcc_core fcc_core_asserts u_fcc_chk (
   .mclk_i(mclk_i), .rst_i(rst_i), .bit_tick_i(bit_tick_i), .rx_bit_i(rx_bit_i),
   .tx_bit_i(tx_bit_i), .wake_i(wake_i), .ctx_i(ctx_i), .err_o(err_o),
   .state_o(state_o), .drv_en_o(drv_en_o), .ecnt_o(ecnt_o)
);

// ==== bench/can_fault_confinement_test.sv ====
// Self-checking bench for the fault confinement core.
// Assumes core, bus node model and checker are compiled before it.
`timescale 1ns/1ps
module can_fault_confinement_test;
   import fcc_pkg::*;
   logic        mclk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
   logic        pwrite_i = 1'b0, bit_tick_i = 1'b0, tx_bit_i = 1'b1, wake_i = 1'b0;
   logic        dom = 1'b0, ack_en = 1'b0, synced = 1'b0, b, se;
   logic        pready_o, pslverr_o, drv_en_o, flag_dom_o, data_tx_ok_o, rx_bit_i;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
   logic [3:0]  pstrb_i = 4'hF;
   logic [15:0] ecnt_o;
   logic [14:0] crc;
   fcc_ctx_t    ctx_i = '0, c;
   fcc_err_t    err_o;
   fcc_state_t  state_o;
   int          failures = 0, checks = 0, tx_fault_count = 0, rx_fault_count = 0;
   always #2.5 mclk_i = ~mclk_i;
   fcc_core i_fcc_core (
      .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .bit_tick_i(bit_tick_i), .rx_bit_i(rx_bit_i), .tx_bit_i(tx_bit_i), .ctx_i(ctx_i),
      .wake_i(wake_i), .err_o(err_o), .state_o(state_o), .drv_en_o(drv_en_o),
      .flag_dom_o(flag_dom_o), .data_tx_ok_o(data_tx_ok_o), .ecnt_o(ecnt_o)
   );
   fcc_bus_node i_fcc_bus_node (
      .tx_bit_i(tx_bit_i), .ack_slot_i(ctx_i.ack_slot), .ack_en_i(ack_en), .dom_i(dom),
      .rx_bit_o(rx_bit_i)
   );
   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   function automatic fcc_state_t est();
      if (!synced) return FCC_SYNC;
      if (tx_fault_count > 255) return FCC_BUSOFF;
      if (tx_fault_count > 127 || rx_fault_count > 127) return FCC_PASSIVE;
      if (tx_fault_count >= 96 || rx_fault_count >= 96) return FCC_WARN;
      return FCC_ACTIVE;
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 16);
      if (k >= 16) begin
         failures++;
         summarize();
      end
      rd = prdata_o;
      se = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // One bit time: tick, then look where the note says results land
   task automatic tk(input logic tx, d, a, input fcc_ctx_t cc, input logic [4:0] e);
      @(posedge mclk_i);
      bit_tick_i <= 1'b1;
      tx_bit_i <= tx;
      dom <= d;
      ack_en <= a;
      ctx_i <= cc;
      @(posedge mclk_i);
      bit_tick_i <= 1'b0;
      ctx_i <= '0;
      // Error pulse stands one cycle only; counts and state are levels
      @(posedge mclk_i);
      #1;
      chk("err", err_o, e);
      @(posedge mclk_i);
      #1;
      chk("ecnt", ecnt_o, {tx_fault_count[7:0], rx_fault_count[7:0]});
      chk("state", state_o, est());
   endtask
   initial begin
      void'($urandom(59));
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1;
      chk("state", state_o, FCC_SYNC);
      apb(1'b0, 12'h000, 32'h0);
      chk("ecnt reg", rd, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      chk("ro write", se, 1'b1);
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmapped", se, 1'b1);
      apb(1'b1, 12'h004, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk("ctrl", rd, 32'h1);
      $display("test registers done");
      for (int i = 0; i < 17; i++) begin
         synced = (i == 16);
         tk(1'b1, i == 5, 1'b0, '0, 5'h00);
      end
      c = '0;
      c.rx_ok = 1'b1;
      c.tx_ok = 1'b1;
      tk(1'b1, 1'b0, 1'b0, c, 5'h00);
      c = '0;
      c.tx_active = 1'b1;
      c.ack_slot = 1'b1;
      tk(1'b1, 1'b0, 1'b1, c, 5'h00);
      for (int i = 0; i < 16; i++) begin
         tx_fault_count += 8;
         tk(1'b1, 1'b0, 1'b0, c, 5'h01);
      end
      tk(1'b1, 1'b0, 1'b0, c, 5'h01);
      chk("flag kind", flag_dom_o, 1'b0);
      c = '0;
      c.err_flag = 1'b1;
      for (int i = 0; i < 7; i++) begin
         if (i == 6) c = '0;
         tk(1'b1, 1'b0, 1'b0, c, 5'h00);
      end
      c = '0;
      c.tx_ok = 1'b1;
      for (int i = 0; i < 3; i++) begin
         tx_fault_count -= 1;
         tk(1'b1, 1'b0, 1'b0, c, 5'h00);
      end
      $display("test transmit counts done");
      c = '0;
      c.in_stuffed = 1'b1;
      for (int i = 0; i < 7; i++) begin
         rx_fault_count += (i == 6);
         tk(1'b1, i > 0, 1'b0, c, (i == 6) ? 5'h08 : 5'h00);
      end
      c = '0;
      c.fixed_bit = 1'b1;
      c.fixed_level = 1'b1;
      rx_fault_count += 1;
      tk(1'b1, 1'b1, 1'b0, c, 5'h04);
      c.eof_last = 1'b1;
      tk(1'b1, 1'b1, 1'b0, c, 5'h00);
      // Random payload, then its own remainder; second pass spoils one bit
      for (int p = 0; p < 2; p++) begin
         crc = 15'h0000;
         for (int i = 0; i < 32; i++) begin
            c = '0;
            c.crc_data = 1'b1;
            c.sof = (i == 0);
            b = (i == 0) ? 1'b0 : 1'($urandom);
            if (i >= 17) b = crc[14] ^ (p == 1 && i == 31);
            tk(1'b1, !b, 1'b0, c, 5'h00);
            crc = {crc[13:0], 1'b0} ^ ((b ^ crc[14]) ? 15'h4599 : 15'h0000);
         end
         c = '0;
         c.crc_check = 1'b1;
         rx_fault_count += p;
         tk(1'b1, 1'b0, 1'b0, c, p ? 5'h02 : 5'h00);
      end
      $display("test receive errors done");
      c = '0;
      c.tx_active = 1'b1;
      while (tx_fault_count <= 255) begin
         tx_fault_count += 8;
         tk(1'b1, 1'b1, 1'b0, c, 5'h10);
      end
      chk("drivers", drv_en_o, 1'b0);
      // A dominant bit early on must restart the current group
      for (int i = 0; i < 1414; i++) begin
         if (i == 1413) begin
            tx_fault_count = 0;
            rx_fault_count = 0;
         end
         tk(1'b1, i == 5, 1'b0, '0, 5'h00);
      end
      chk("drivers", drv_en_o, 1'b1);
      $display("test bus off done");
      c = '0;
      c.frame_end = 1'b1;
      for (int i = 0; i < 4; i++) begin
         tk(1'b1, 1'b0, 1'b0, c, 5'h00);
         c = '0;
         chk("ifs", data_tx_ok_o, i == 3);
      end
      // Last flag sent was passive, so the dominant run steps at eight
      c = '0;
      c.flag_tail = 1'b1;
      for (int i = 0; i < 8; i++) begin
         rx_fault_count += (i == 0 || i == 7) ? 8 : 0;
         tk(1'b1, 1'b1, 1'b0, c, 5'h00);
      end
      $display("test dominant runs done");
      @(posedge mclk_i);
      wake_i <= 1'b1;
      @(posedge mclk_i);
      wake_i <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         synced = (i == 10);
         tk(1'b1, 1'b0, 1'b0, '0, 5'h00);
      end
      $display("test wake done");
      summarize();
   end
endmodule
